// ### hdl/spiqp_decoder.sv
// Serial command decoder of a quad digital potentiometer with nonvolatile settings
module spiqp_decoder
	import spiqp_pkg::*;
#(
	parameter int unsigned NV_CYCLES = NV_CYCLES_DEF,
	// Arbitrary device type code
	parameter logic [3:0] DEVICE_TYPE = 4'hA,
	parameter logic [WIPER_W-1:0] STORED_INIT = 6'h00
) (
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic SCK_I,
	input wire logic CS_N_I,
	input wire logic SI_I,
	input wire logic [1:0] ADDR_STRAP_I,
	output logic SO_O,
	output logic SO_OE_N_O,
	output logic [NUM_POTS*NUM_TAPS-1:0] WIPER_TAP_O,
	output logic WIP_O
);
	localparam int CNT_W = $clog2(NV_CYCLES + 1);
	localparam logic [NUM_TAPS-1:0] TAP_ONE = {{(NUM_TAPS-1){1'b0}}, 1'b1};
	localparam logic [CNT_W-1:0] NV_LOAD = CNT_W'(NV_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_DEC = CNT_W'(1);

	typedef struct packed {
		spiqp_lstate_t state;
		logic [2:0] bitcnt;
		logic [BYTE_W-1:0] shift;
	} spiqp_frame_t;
	// Link state that must survive chip select: event toggles and their payload
	typedef struct packed {
		logic [1:0] strap1, strap2;
		logic cmd_tgl, wr_tgl, step_tgl, step_up;
		logic [BYTE_W-1:0] instr, wdata;
	} spiqp_hold_t;

	typedef struct packed {
		logic so;
		logic oe_n;
		logic [BYTE_W-1:0] osh;
	} spiqp_out_t;
	typedef struct packed {
		logic cs1, cs2, cs_seen;
		logic cmd1, cmd2, cmd_seen;
		logic wr1, wr2, wr_seen;
		logic st1, st2, st_seen;
		logic [NUM_POTS-1:0][WIPER_W-1:0] wiper;
		logic [NUM_POTS-1:0][NUM_STORE-1:0][WIPER_W-1:0] stored;
		logic pend;
		logic [NUM_POTS-1:0] pmask;
		logic [1:0] preg;
		logic [NUM_POTS-1:0][WIPER_W-1:0] pval;
		logic wip;
		logic [CNT_W-1:0] nvcnt;
		logic [BYTE_W-1:0] rd_word;
		logic [NUM_POTS*NUM_TAPS-1:0] taps;
	} spiqp_core_t;

	localparam spiqp_frame_t FRAME_RST = '{state: LS_ID, default: '0};
	localparam spiqp_out_t OUT_RST = '{oe_n: 1'b1, default: '0};
	localparam spiqp_core_t CORE_RST = '{
		cs1: 1'b1, cs2: 1'b1, cs_seen: 1'b1,
		wiper: {NUM_POTS{STORED_INIT}},
		stored: {(NUM_POTS*NUM_STORE){STORED_INIT}},
		taps: {NUM_POTS{TAP_ONE << STORED_INIT}},
		default: '0};

	function automatic logic is_read(input logic [BYTE_W-1:0] ins);
		return ins[7:4] == OP_RD_WIPER || ins[7:4] == OP_RD_STORE || ins == INSTR_STATUS;
	endfunction : is_read

	function automatic logic is_write(input logic [BYTE_W-1:0] ins);
		return ins[7:4] == OP_WR_WIPER || ins[7:4] == OP_WR_STORE;
	endfunction : is_write

	// Opcodes whose register or pot field is fixed must carry it as zero
	function automatic logic instr_ok(input logic [BYTE_W-1:0] ins);
		logic ok;
		ok = 1'b0;
		unique case (ins[7:4])
			OP_RD_WIPER, OP_WR_WIPER, OP_STEP: ok = ins[3:2] == SEL_ZERO;
			OP_GXFR_TO_WIPER, OP_GXFR_TO_STORE: ok = ins[1:0] == SEL_ZERO;
			OP_RD_STORE, OP_WR_STORE, OP_XFR_TO_WIPER, OP_XFR_TO_STORE: ok = 1'b1;
			default: ok = ins == INSTR_STATUS;
		endcase
		return ok;
	endfunction : instr_ok

	function automatic logic [WIPER_W-1:0] sat_step(input logic [WIPER_W-1:0] w,
			input logic up);
		logic [WIPER_W-1:0] r;
		r = w;
		if (up && w != TAP_MAX) begin
			r = w + TAP_STEP;
		end else if (!up && w != TAP_MIN) begin
			r = w - TAP_STEP;
		end
		return r;
	endfunction : sat_step

	function automatic logic [NUM_TAPS-1:0] tap_decode(input logic [WIPER_W-1:0] w);
		return TAP_ONE << w;
	endfunction : tap_decode

	spiqp_frame_t f, next_f;
	spiqp_hold_t h, next_h;
	spiqp_out_t o, next_o;
	spiqp_core_t c, next_c;
	logic link_rst, cmd_ev, wr_ev, st_ev, cs_rise;
	logic [3:0] op;
	logic [1:0] pot, rsel;
	logic [WIPER_W-1:0] cur_wiper, sel_store, wdata_w;
	// Chip select high holds the frame logic idle, so a rise aborts any command
	assign link_rst = RESET_I | CS_N_I;

	always_comb begin
		next_f = f;
		next_h = h;
		next_h.strap1 = ADDR_STRAP_I;
		next_h.strap2 = h.strap1;
		next_f.shift = {f.shift[BYTE_W-2:0], SI_I};
		next_f.bitcnt = f.bitcnt + BIT_INC;
		unique case (f.state)
			LS_ID: begin
				// Middle ID bits are not checked, a host that sends ones still matches
				if (f.bitcnt == BIT_LAST) begin
					if (next_f.shift[7:4] == DEVICE_TYPE && next_f.shift[1:0] == h.strap2) begin
						next_f.state = LS_INSTR;
					end else begin
						next_f.state = LS_DONE;
					end
				end
			end
			LS_INSTR: begin
				if (f.bitcnt == BIT_LAST) begin
					next_h.instr = next_f.shift;
					next_f.state = LS_DONE;
					if (instr_ok(next_f.shift)) begin
						next_h.cmd_tgl = ~h.cmd_tgl;
						if (is_read(next_f.shift) || is_write(next_f.shift)) begin
							next_f.state = LS_DATA;
						end else if (next_f.shift[7:4] == OP_STEP) begin
							next_f.state = LS_STEP;
						end
					end
				end
			end
			LS_DATA: begin
				if (f.bitcnt == BIT_LAST) begin
					next_f.state = LS_DONE;
					if (is_write(h.instr)) begin
						next_h.wdata = next_f.shift;
						next_h.wr_tgl = ~h.wr_tgl;
					end
				end
			end
			LS_STEP: begin
				// One step per rising edge until chip select rises
				next_h.step_up = SI_I;
				next_h.step_tgl = ~h.step_tgl;
			end
			LS_DONE: begin
				next_f.bitcnt = f.bitcnt;
			end
			default: next_f.state = LS_DONE;
		endcase
	end

	always_ff @(posedge SCK_I or posedge link_rst) begin
		if (link_rst) begin
			f <= FRAME_RST;
		end else begin
			f <= next_f;
		end
	end

	always_ff @(posedge SCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			h <= '0;
		end else begin
			h <= next_h;
		end
	end

	// Read byte is taken half a serial clock after the instruction toggle; the core
	// settles it within a few MCLK cycles, far inside that half period.
	always_comb begin
		next_o = o;
		next_o.oe_n = 1'b1;
		next_o.so = 1'b0;
		if (f.state == LS_DATA && is_read(h.instr)) begin
			next_o.oe_n = 1'b0;
			if (f.bitcnt == BIT_FIRST) begin
				next_o.so = c.rd_word[BYTE_W-1];
				next_o.osh = {c.rd_word[BYTE_W-2:0], 1'b0};
			end else begin
				next_o.so = o.osh[BYTE_W-1];
				next_o.osh = {o.osh[BYTE_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(negedge SCK_I or posedge link_rst) begin
		if (link_rst) begin
			o <= OUT_RST;
		end else begin
			o <= next_o;
		end
	end

	assign cmd_ev = c.cmd2 != c.cmd_seen;
	assign wr_ev = c.wr2 != c.wr_seen;
	assign st_ev = c.st2 != c.st_seen;
	assign cs_rise = c.cs2 & ~c.cs_seen;
	assign op = h.instr[7:4];
	assign rsel = h.instr[3:2];
	assign pot = h.instr[1:0];
	assign cur_wiper = c.wiper[pot];
	assign sel_store = c.stored[pot][rsel];
	assign wdata_w = h.wdata[WIPER_W-1:0];

	always_comb begin
		next_c = c;
		next_c.cs1 = CS_N_I;
		next_c.cs2 = c.cs1;
		next_c.cs_seen = c.cs2;
		next_c.cmd1 = h.cmd_tgl;
		next_c.cmd2 = c.cmd1;
		next_c.cmd_seen = c.cmd2;
		next_c.wr1 = h.wr_tgl;
		next_c.wr2 = c.wr1;
		next_c.wr_seen = c.wr2;
		next_c.st1 = h.step_tgl;
		next_c.st2 = c.st1;
		next_c.st_seen = c.st2;
		if (cmd_ev) begin
			unique case (op)
				OP_RD_WIPER: next_c.rd_word = BYTE_W'(cur_wiper);
				OP_RD_STORE: next_c.rd_word = BYTE_W'(sel_store);
				OP_XFR_TO_WIPER: next_c.wiper[pot] = sel_store;
				OP_GXFR_TO_WIPER: begin
					for (int i = 0; i < NUM_POTS; i++) begin
						next_c.wiper[i] = c.stored[i][rsel];
					end
				end
				OP_XFR_TO_STORE: begin
					// A new nonvolatile request is dropped while programming runs
					if (!c.wip) begin
						next_c.pend = 1'b1;
						next_c.preg = rsel;
						next_c.pmask = NUM_POTS'(1) << pot;
						next_c.pval[pot] = cur_wiper;
					end
				end
				OP_GXFR_TO_STORE: begin
					if (!c.wip) begin
						next_c.pend = 1'b1;
						next_c.preg = rsel;
						next_c.pmask = '1;
						next_c.pval = c.wiper;
					end
				end
				default: begin
					if (h.instr == INSTR_STATUS) begin
						next_c.rd_word = BYTE_W'(c.wip);
					end
				end
			endcase
		end
		if (wr_ev && op == OP_WR_WIPER) begin
			next_c.wiper[pot] = wdata_w;
		end
		if (wr_ev && op == OP_WR_STORE && !c.wip) begin
			next_c.pend = 1'b1;
			next_c.preg = rsel;
			next_c.pmask = NUM_POTS'(1) << pot;
			next_c.pval[pot] = wdata_w;
		end
		if (st_ev && op == OP_STEP) begin
			next_c.wiper[pot] = sat_step(cur_wiper, h.step_up);
		end
		// Commit reads next_c so a request synchronised with the rise is not lost
		if (cs_rise && next_c.pend) begin
			for (int i = 0; i < NUM_POTS; i++) begin
				if (next_c.pmask[i]) begin
					next_c.stored[i][next_c.preg] = next_c.pval[i];
				end
			end
			next_c.pend = 1'b0;
			next_c.wip = 1'b1;
			next_c.nvcnt = NV_LOAD;
		end else if (c.wip) begin
			if (c.nvcnt == CNT_ZERO) begin
				next_c.wip = 1'b0;
			end else begin
				next_c.nvcnt = c.nvcnt - CNT_DEC;
			end
		end else if (cs_rise) begin
			next_c.pend = 1'b0;
		end
		for (int i = 0; i < NUM_POTS; i++) begin
			next_c.taps[i*NUM_TAPS +: NUM_TAPS] = tap_decode(c.wiper[i]);
		end
	end

	// Reset stands for power-up: wipers equal stored index zero by construction
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			c <= CORE_RST;
		end else begin
			c <= next_c;
		end
	end

	assign SO_O = o.so;
	assign SO_OE_N_O = o.oe_n;
	assign WIPER_TAP_O = c.taps;
	assign WIP_O = c.wip;

	sequence step_s(logic up);
		st_ev && op == OP_STEP && h.step_up == up;
	endsequence

	sequence wip_hold_s;
		c.wip [*3];
	endsequence

	id_match_a: assert property (@(posedge SCK_I) disable iff (link_rst)
		f.state == LS_ID && f.bitcnt == BIT_LAST |=> (f.state == LS_INSTR) ==
		(f.shift[1:0] == $past(h.strap2) &&
		f.shift[BYTE_W-1:4] == DEVICE_TYPE))
		else $error("ID byte decision wrong");
	mismatch_quiet_a: assert property (@(negedge SCK_I) disable iff (link_rst)
		f.state == LS_DONE |=> o.oe_n)
		else $error("Output driven after frame ended");
	read_wiper_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		cmd_ev && op == OP_RD_WIPER |=> c.rd_word == BYTE_W'($past(cur_wiper)))
		else $error("Wiper read byte wrong");
	wiper_write_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		wr_ev && op == OP_WR_WIPER |=> c.wiper[$past(pot)] == $past(wdata_w))
		else $error("Wiper write not applied");
	xfr_wiper_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		cmd_ev && op == OP_XFR_TO_WIPER |=> c.wiper[$past(pot)] == $past(sel_store))
		else $error("Stored to wiper copy wrong");
	step_up_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		step_s(1'b1) ##0 cur_wiper != TAP_MAX |=>
		c.wiper[$past(pot)] == $past(cur_wiper) + TAP_STEP)
		else $error("Up step wrong");
	step_down_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		step_s(1'b0) ##0 cur_wiper != TAP_MIN |=>
		c.wiper[$past(pot)] == $past(cur_wiper) - TAP_STEP)
		else $error("Down step wrong");
	step_hold_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		step_s(1'b1) ##0 cur_wiper == TAP_MAX |=> c.wiper[$past(pot)] == TAP_MAX)
		else $error("Wiper wrapped at top");
	nv_commit_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		cs_rise && c.pend |=> wip_hold_s)
		else $error("Progress flag not held after commit");
	nv_time_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		$rose(c.wip) |-> c.nvcnt == NV_LOAD)
		else $error("Programming time load wrong");
	status_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		cmd_ev && h.instr == INSTR_STATUS |=> c.rd_word == BYTE_W'($past(c.wip)))
		else $error("Status byte wrong");
	tap_onehot_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		$onehot(c.taps[NUM_TAPS-1:0]) && $onehot(c.taps[NUM_POTS*NUM_TAPS-1 -: NUM_TAPS]))
		else $error("Tap select not one-hot");
endmodule : spiqp_decoder

// ### shared/spiqp_pkg.sv
// Constants and types shared by the quad pot serial command decoder
package spiqp_pkg;
	localparam int NUM_POTS = 4;
	localparam int NUM_STORE = 4;
	localparam int WIPER_W = 6;
	localparam int NUM_TAPS = 64;
	localparam int BYTE_W = 8;
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'hA;
	localparam logic [3:0] OP_RD_STORE = 4'hB;
	localparam logic [3:0] OP_WR_STORE = 4'hC;
	localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
	localparam logic [3:0] OP_XFR_TO_STORE = 4'hE;
	localparam logic [3:0] OP_GXFR_TO_WIPER = 4'h1;
	localparam logic [3:0] OP_GXFR_TO_STORE = 4'h8;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam logic [7:0] INSTR_STATUS = 8'h51;
	localparam logic [1:0] SEL_ZERO = 2'h0;
	localparam logic [5:0] TAP_MAX = 6'h3F;
	localparam logic [5:0] TAP_MIN = 6'h00;
	localparam logic [5:0] TAP_STEP = 6'h01;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_INC = 3'h1;
	// Nonvolatile programming time, longest figure, and the clock it is counted on
	localparam int NV_PROGRAM_TIME_MS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int MCLK_PERIOD_NS = 4;
	localparam int NV_CYCLES_DEF = NV_PROGRAM_TIME_MS * NS_PER_MS / MCLK_PERIOD_NS;
	typedef enum logic [2:0] {
		LS_ID = 3'b000,
		LS_INSTR = 3'b001,
		LS_DATA = 3'b011,
		LS_STEP = 3'b010,
		LS_DONE = 3'b110
	} spiqp_lstate_t;
endpackage : spiqp_pkg

// ### dv/spiqp_host_model.sv
// Host serial master model that frames commands to the pot decoder
module spiqp_host_model (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_n_i
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime HALF = 62.5ns;
	logic oe_seen;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		oe_seen = 1'b0;
	end
	// Sends nbits from the top of bits, MSB first; SCK stands low between frames
	task automatic frame(input logic [127:0] bits, input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		oe_seen = 1'b0;
		// Odd offset keeps the link clock out of phase with the core clock
		#1.3ns;
		cs_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si_o = bits[127-i];
			#(HALF);
			sck_o = 1'b1;
			// Released line reads as pulled high, so a missing enable shows
			rd = {rd[6:0], (so_oe_n_i === 1'b0) ? so_i : 1'b1};
			if (so_oe_n_i === 1'b0) begin
				oe_seen = 1'b1;
			end
			#(HALF);
			sck_o = 1'b0;
		end
		#(HALF);
		cs_n_o = 1'b1;
		// Stale data must not look like a held bit
		si_o = ~si_o;
		#200ns;
	endtask : frame
endmodule : spiqp_host_model

// ### dv/spiqp_decoder_tb.sv
// Self-checking bench of the quad pot serial command decoder
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
	$display("BAD %s expected %h seen %h", nm, ex, got); end end
module spiqp_decoder_tb
	import spiqp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NV_SIM = 1000;
	localparam logic [3:0] DEV_TYPE = 4'h6; // Arbitrary type code
	logic mclk, rst, sck, cs_n, si, so, so_oe_n, wip;
	logic [1:0] strap;
	logic [NUM_POTS*NUM_TAPS-1:0] taps;
	logic [WIPER_W-1:0] wiper [NUM_POTS];
	logic [WIPER_W-1:0] store [NUM_POTS][NUM_STORE];
	logic [3:0] ops [10] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h1, 4'h8, 4'h2, 4'h5};
	logic [7:0] rd;
	int err_count, n_compared;

	spiqp_decoder #(.NV_CYCLES(NV_SIM), .DEVICE_TYPE(DEV_TYPE)) dut (.MCLK_I(mclk),
		.RESET_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .ADDR_STRAP_I(strap),
		.SO_O(so), .SO_OE_N_O(so_oe_n), .WIPER_TAP_O(taps), .WIP_O(wip));
	spiqp_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
		.so_oe_n_i(so_oe_n));

	initial begin
		mclk = 1'b0;
		forever #2ns mclk = ~mclk;
	end

	function automatic logic [7:0] id_byte();
		return {DEV_TYPE, 2'b00, strap};
	endfunction : id_byte

	function automatic logic [5:0] sat(input logic [5:0] w, input logic up);
		if (up) begin
			return (w == TAP_MAX) ? TAP_MAX : w + TAP_STEP;
		end
		return (w == TAP_MIN) ? TAP_MIN : w - TAP_STEP;
	endfunction : sat

	task automatic wrap_up();
		$display("Counts: compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	task automatic check_taps();
		for (int p = 0; p < NUM_POTS; p++) begin
			`CHK("tap", 64'h1 << wiper[p], taps[p*NUM_TAPS +: NUM_TAPS])
		end
		`CHK("so_oe_n", 1'b1, so_oe_n)
	endtask : check_taps

	task automatic wait_wip();
		int k;
		k = 0;
		while (wip !== 1'b0 && k < NV_SIM + 100) begin
			@(negedge mclk);
			k++;
		end
		if (wip !== 1'b0) begin
			err_count++;
			$display("BAD wip_timeout expected 0 seen %b", wip);
			wrap_up();
		end
	endtask : wait_wip

	task automatic do_cmd(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p,
		input logic [7:0] d, input int n, input logic [111:0] sb);
		logic [127:0] b;
		logic [7:0] ex;
		int nb;
		if (op inside {OP_RD_WIPER, OP_WR_WIPER, OP_STEP}) r = SEL_ZERO;
		if (op inside {OP_GXFR_TO_WIPER, OP_GXFR_TO_STORE}) p = SEL_ZERO;
		if (op == INSTR_STATUS[7:4]) {r, p} = INSTR_STATUS[3:0];
		b = {id_byte(), op, r, p, d, 104'h0};
		nb = 24;
		ex = 8'h00;
		case (op)
			OP_RD_WIPER: ex = {2'b00, wiper[p]};
			OP_RD_STORE: ex = {2'b00, store[p][r]};
			OP_WR_WIPER: wiper[p] = d[5:0];
			OP_WR_STORE: store[p][r] = d[5:0];
			OP_XFR_TO_WIPER: wiper[p] = store[p][r];
			OP_XFR_TO_STORE: store[p][r] = wiper[p];
			OP_GXFR_TO_WIPER: for (int i = 0; i < NUM_POTS; i++) wiper[i] = store[i][r];
			OP_GXFR_TO_STORE: for (int i = 0; i < NUM_POTS; i++) store[i][r] = wiper[i];
			OP_STEP: begin
				b[111:0] = sb;
				nb = 16 + n;
				for (int i = 0; i < n; i++) wiper[p] = sat(wiper[p], sb[111-i]);
			end
			default: ;
		endcase
		if (op inside {OP_XFR_TO_WIPER, OP_XFR_TO_STORE, OP_GXFR_TO_WIPER, OP_GXFR_TO_STORE}) nb = 16;
		host.frame(b, nb, rd);
		if (op inside {OP_RD_WIPER, OP_RD_STORE, 4'h5}) begin
			`CHK("read", ex, rd)
		end
		if (op inside {OP_WR_STORE, OP_XFR_TO_STORE, OP_GXFR_TO_STORE}) begin
			`CHK("wip", 1'b1, wip)
			host.frame({id_byte(), INSTR_STATUS, 112'h0}, 24, rd);
			`CHK("status", 8'h01, rd)
			wait_wip();
		end
		check_taps();
	endtask : do_cmd

	initial begin
		err_count = 0;
		n_compared = 0;
		rst = 1'b1;
		strap = 2'b00;
		void'($urandom(32'h61c9));
		for (int i = 0; i < NUM_POTS; i++) begin
			wiper[i] = stored_init_tb();
			for (int j = 0; j < NUM_STORE; j++) store[i][j] = 6'h00;
		end
		repeat (10) @(negedge mclk);
		strap = 2'($urandom);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		check_taps();
		`CHK("wip_reset", 1'b0, wip)
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			do_cmd(ops[i < 10 ? i : $urandom % 10], 2'($urandom), 2'($urandom),
				8'($urandom), 1 + $urandom % 12, {$urandom, $urandom, $urandom, 16'($urandom)});
		end
		$display("test random commands done");
		do_cmd(OP_STEP, 2'h0, 2'h1, 8'h00, 70, {112{1'b1}});
		do_cmd(OP_STEP, 2'h0, 2'h1, 8'h00, 70, {112{1'b0}});
		$display("test step limits done");
		host.frame({DEV_TYPE, 2'b00, ~strap, OP_WR_WIPER, 4'h2, 8'h2A, 104'h0}, 24, rd);
		host.frame({~DEV_TYPE, 2'b00, strap, OP_WR_WIPER, 4'h2, 8'h15, 104'h0}, 24, rd);
		host.frame({DEV_TYPE, 2'b00, ~strap, OP_RD_WIPER, 4'h2, 112'h0}, 24, rd);
		`CHK("oe_seen", 1'b0, host.oe_seen)
		check_taps();
		// Wiper write with a nonzero register field is an illegal instruction
		host.frame({id_byte(), OP_WR_WIPER, 4'h6, 8'h2A, 104'h0}, 24, rd);
		check_taps();
		host.frame({id_byte(), OP_WR_WIPER, 4'h3, 8'h2A, 104'h0}, 20, rd);
		check_taps();
		do_cmd(OP_RD_WIPER, 2'h0, 2'h3, 8'h00, 0, 112'h0);
		// Second store write lands while programming runs and must be dropped
		host.frame({id_byte(), OP_WR_STORE, 4'h0, 8'h11, 104'h0}, 24, rd);
		store[0][0] = 6'h11;
		host.frame({id_byte(), OP_WR_STORE, 4'h0, 8'h22, 104'h0}, 24, rd);
		wait_wip();
		do_cmd(OP_RD_STORE, 2'h0, 2'h0, 8'h00, 0, 112'h0);
		$display("test refusals done");
		wrap_up();
	end

	function automatic logic [5:0] stored_init_tb();
		return 6'h00;
	endfunction : stored_init_tb
endmodule : spiqp_decoder_tb
